// ---- logic/wdls_pkg.sv ----
// Package for the watchdog configuration lock and crossing status block.
// Assumes a 100 MHz system clock and a watchdog tick derived from it.
package wdls_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_STAT = 8'h01;
    localparam logic [7:0] IDX_KEY = 8'h02;
    localparam logic [11:0] ADDR_CTRL = 12'({IDX_CTRL, 2'b00});
    localparam logic [11:0] ADDR_STAT = 12'({IDX_STAT, 2'b00});
    localparam logic [11:0] ADDR_KEY = 12'({IDX_KEY, 2'b00});
    // Field positions.
    localparam int LOCK_BIT = 7;
    localparam int BUSY_BIT = 0;
    localparam int PER_LSB = 0;
    localparam int PER_W = 4;
    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // Unlock key and the number of bus accesses the unlock stays open.
    localparam logic [7:0] UNLOCK_KEY = 8'hd8;
    localparam logic [2:0] UNLOCK_SPAN = 3'h4;
    // Watchdog ticks needed to cross a value or a refresh.
    localparam logic [1:0] SYNC_TICKS = 2'h3;
    // Timeout decode: code 1 is 8 watchdog cycles, each code up to 11 doubles it.
    localparam logic [3:0] PER_OFF = 4'h0;
    localparam logic [3:0] PER_MAX = 4'hb;
    localparam logic [13:0] TO_BASE = 14'h0008;
    localparam logic [13:0] TO_NONE = 14'h0000;
    // Clock rates in hertz and the divider between them.
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int WDT_CLK_HZ = 1_000;
    localparam int WDT_DIV_DEF = SYS_CLK_HZ / WDT_CLK_HZ;
endpackage

// ---- logic/wdls_top.sv ----
// Watchdog configuration lock, protected write and crossing status, with APB access.
// Assumes an APB master on ref_clk_in and a refresh request pulse from the core.
`timescale 1ns/10ps
`default_nettype none
module wdls_top #(
    parameter int WDT_DIV = wdls_pkg::WDT_DIV_DEF
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Boot configuration and debug.
    input wire logic boot_load_in,
    input wire logic [7:0] boot_cfg_in,
    input wire logic debug_in,
    // Refresh request from the core.
    input wire logic refresh_in,
    // Watchdog-side results.
    output logic [7:0] ctrl_active_out,
    output logic wdt_enable_out,
    output logic [13:0] timeout_cycles_out,
    output logic refresh_sync_out,
    output logic lock_out,
    output logic busy_out
);
    logic [16:0] div_cnt_r, div_cnt_nxt;
    logic tick_r, tick_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [7:0] ctrl_r, ctrl_nxt, act_r, act_nxt;
    logic lock_r, lock_nxt, busy_r, busy_nxt;
    logic [1:0] sync_cnt_r, sync_cnt_nxt;
    logic [2:0] unl_cnt_r, unl_cnt_nxt;
    logic ref_pend_r, ref_pend_nxt, ref_out_r, ref_out_nxt;
    logic [1:0] ref_cnt_r, ref_cnt_nxt;
    logic en_r, en_nxt;
    logic [13:0] tmo_r, tmo_nxt;
    logic acc, wr_ctrl, wr_stat, wr_key, unlocked, ctrl_take;

    // Bus access decode; an access completes in the cycle pready is high.
    assign acc = psel_in & penable_in & pready_r;
    assign wr_ctrl = acc & pwrite_in & (paddr_in == wdls_pkg::ADDR_CTRL);
    assign wr_stat = acc & pwrite_in & (paddr_in == wdls_pkg::ADDR_STAT);
    assign wr_key = acc & pwrite_in & (paddr_in == wdls_pkg::ADDR_KEY);
    assign unlocked = (unl_cnt_r != 3'h0);
    assign ctrl_take = wr_ctrl & unlocked & ~lock_r & ~busy_r;

    // Divider that makes the one-cycle watchdog tick.
    always_comb begin
        div_cnt_nxt = div_cnt_r + 17'h00001;
        tick_nxt = 1'b0;
        if (div_cnt_r == 17'(WDT_DIV - 1)) begin
            div_cnt_nxt = 17'h00000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    // APB answer: no wait state, read data and error prepared in setup.
    always_comb begin
        pready_nxt = psel_in & ~penable_in;
        pslverr_nxt = 1'b0;
        prdata_nxt = wdls_pkg::RD_ZERO;
        if (psel_in & ~penable_in) begin
            unique case (paddr_in)
                wdls_pkg::ADDR_CTRL: prdata_nxt[7:0] = ctrl_r;
                wdls_pkg::ADDR_STAT: begin
                    prdata_nxt[wdls_pkg::LOCK_BIT] = lock_r;
                    prdata_nxt[wdls_pkg::BUSY_BIT] = busy_r;
                end
                wdls_pkg::ADDR_KEY: prdata_nxt = wdls_pkg::RD_ZERO;
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= wdls_pkg::RD_ZERO;
        end else begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // Unlock window: the key opens it, each later access uses one slot.
    always_comb begin
        unl_cnt_nxt = unl_cnt_r;
        if (wr_key && pwdata_in[7:0] == wdls_pkg::UNLOCK_KEY) begin
            unl_cnt_nxt = wdls_pkg::UNLOCK_SPAN;
        end else if (acc && unlocked) begin
            unl_cnt_nxt = unl_cnt_r - 3'h1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            unl_cnt_r <= 3'h0;
        end else begin
            unl_cnt_r <= unl_cnt_nxt;
        end
    end

    // Control staging, lock bit and crossing into the watchdog tick domain.
    always_comb begin
        ctrl_nxt = ctrl_r;
        act_nxt = act_r;
        lock_nxt = lock_r;
        busy_nxt = busy_r;
        sync_cnt_nxt = sync_cnt_r;
        if (busy_r && tick_r) begin
            sync_cnt_nxt = sync_cnt_r + 2'h1;
            if (sync_cnt_r == wdls_pkg::SYNC_TICKS - 2'h1) begin
                act_nxt = ctrl_r;
                busy_nxt = 1'b0;
            end
        end
        if (boot_load_in) begin
            ctrl_nxt = boot_cfg_in;
            busy_nxt = 1'b1;
            sync_cnt_nxt = 2'h0;
            if (boot_cfg_in[wdls_pkg::PER_LSB +: wdls_pkg::PER_W] != wdls_pkg::PER_OFF) begin
                lock_nxt = 1'b1;
            end
        end else if (ctrl_take) begin
            ctrl_nxt = pwdata_in[7:0];
            busy_nxt = 1'b1;
            sync_cnt_nxt = 2'h0;
        end else if (wr_stat && unlocked) begin
            // The busy bit is read only, so only the lock bit reacts here.
            if (pwdata_in[wdls_pkg::LOCK_BIT]) begin
                lock_nxt = 1'b1;
            end else if (debug_in) begin
                lock_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r <= wdls_pkg::CTRL_RST;
            act_r <= wdls_pkg::CTRL_RST;
            lock_r <= 1'b0;
            busy_r <= 1'b0;
            sync_cnt_r <= 2'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            act_r <= act_nxt;
            lock_r <= lock_nxt;
            busy_r <= busy_nxt;
            sync_cnt_r <= sync_cnt_nxt;
        end
    end

    // Timeout decode of the active period field and the enable.
    always_comb begin
        logic [3:0] per;
        per = act_nxt[wdls_pkg::PER_LSB +: wdls_pkg::PER_W];
        en_nxt = (per != wdls_pkg::PER_OFF);
        tmo_nxt = wdls_pkg::TO_NONE;
        if (per != wdls_pkg::PER_OFF && per <= wdls_pkg::PER_MAX) begin
            tmo_nxt = wdls_pkg::TO_BASE << (per - 4'h1);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_r <= 1'b0;
            tmo_r <= wdls_pkg::TO_NONE;
        end else begin
            en_r <= en_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    // Refresh crossing; a request while one is pending is dropped.
    always_comb begin
        ref_pend_nxt = ref_pend_r;
        ref_cnt_nxt = ref_cnt_r;
        ref_out_nxt = 1'b0;
        if (ref_pend_r) begin
            if (tick_r) begin
                ref_cnt_nxt = ref_cnt_r + 2'h1;
                if (ref_cnt_r == wdls_pkg::SYNC_TICKS - 2'h1) begin
                    ref_pend_nxt = 1'b0;
                    ref_out_nxt = 1'b1;
                end
            end
        end else if (refresh_in) begin
            ref_pend_nxt = 1'b1;
            ref_cnt_nxt = 2'h0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_pend_r <= 1'b0;
            ref_cnt_r <= 2'h0;
            ref_out_r <= 1'b0;
        end else begin
            ref_pend_r <= ref_pend_nxt;
            ref_cnt_r <= ref_cnt_nxt;
            ref_out_r <= ref_out_nxt;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign ctrl_active_out = act_r;
    assign wdt_enable_out = en_r;
    assign timeout_cycles_out = tmo_r;
    assign refresh_sync_out = ref_out_r;
    assign lock_out = lock_r;
    assign busy_out = busy_r;

    // Checks on the lock, crossing, decode and refresh behaviour.
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    property p_code6;
        en_r && act_r[3:0] == 4'h6 && $stable(act_r) |-> tmo_r == 14'h0100;
    endproperty
    a_code6: assert property (p_code6) else $error("Code 6 timeout wrong.");

    property p_codeb;
        $stable(act_r) && act_r[3:0] == 4'hb |-> tmo_r == 14'h2000;
    endproperty
    a_codeb: assert property (p_codeb) else $error("Code B timeout wrong.");

    property p_lock_block;
        wr_ctrl && lock_r && !boot_load_in |=> $stable(ctrl_r);
    endproperty
    a_lock_block: assert property (p_lock_block) else $error("Locked control changed.");

    property p_lock_set;
        wr_stat && unlocked && pwdata_in[7] && !boot_load_in |=> lock_r;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("Lock not set.");

    property p_lock_clear;
        $fell(lock_r) |-> $past(debug_in);
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("Lock cleared outside debug.");

    property p_boot_lock;
        boot_load_in && boot_cfg_in[3:0] != 4'h0 |=> lock_r ##1 lock_r || debug_in;
    endproperty
    a_boot_lock: assert property (p_boot_lock) else $error("Boot did not lock.");

    property p_unlock_need;
        (wr_stat || wr_ctrl) && !unlocked && !boot_load_in |=> $stable(lock_r) && $stable(ctrl_r);
    endproperty
    a_unlock_need: assert property (p_unlock_need) else $error("Write without unlock.");

    property p_busy_rise;
        ctrl_take && !boot_load_in |=> busy_r && ctrl_r == $past(pwdata_in[7:0]);
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("Busy not raised.");

    property p_busy_fall;
        busy_r && tick_r && sync_cnt_r == 2'h2 && !boot_load_in && !ctrl_take |=> !busy_r;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("Busy not cleared.");

    property p_act_on_fall;
        $changed(act_r) |-> $fell(busy_r) || boot_load_in || $past(boot_load_in);
    endproperty
    a_act_on_fall: assert property (p_act_on_fall) else $error("Early control effect.");

    property p_ref_ignore;
        ref_pend_r && refresh_in && !tick_r |=> ref_pend_r && $stable(ref_cnt_r);
    endproperty
    a_ref_ignore: assert property (p_ref_ignore) else $error("Refresh not ignored.");

    // Further decode points, the read-only busy bit, the unlock window and the refresh pulse.
    property p_code7;
        act_r[3:0] == 4'h7 |-> tmo_r == 14'h0200;
    endproperty
    a_code7: assert property (p_code7) else $error("Code 7 timeout wrong.");

    property p_code9;
        act_r[3:0] == 4'h9 |-> tmo_r == 14'h0800;
    endproperty
    a_code9: assert property (p_code9) else $error("Code 9 timeout wrong.");

    property p_busy_ro;
        wr_stat && !busy_r && !boot_load_in |=> !busy_r;
    endproperty
    a_busy_ro: assert property (p_busy_ro) else $error("Status write set busy.");

    property p_enable;
        en_r == (act_r[3:0] != 4'h0);
    endproperty
    a_enable: assert property (p_enable) else $error("Enable does not follow period.");

    property p_unlock_closed;
        !unlocked && !wr_key |=> !unlocked;
    endproperty
    a_unlock_closed: assert property (p_unlock_closed) else $error("Unlock opened without key.");

    property p_ref_single;
        ref_out_r |=> !ref_out_r;
    endproperty
    a_ref_single: assert property (p_ref_single) else $error("Refresh pulse too long.");

    c_ctrl_write: cover property (ctrl_take);
    c_busy_done: cover property ($fell(busy_r));
    c_refresh: cover property (ref_out_r);
    c_lock_clear: cover property ($fell(lock_r));
    c_boot_lock: cover property (boot_load_in && boot_cfg_in[3:0] != 4'h0);
endmodule
`default_nettype wire

// ---- testbench/tb_wdls_top.sv ----
// Self-checking bench for the watchdog lock and crossing status block.
// Assumes the package and design are compiled first; the bench is the APB master.
`timescale 1ns/10ps
`default_nettype none
module tb_wdls_top;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic boot_load_in = 1'b0;
    logic debug_in = 1'b0;
    logic refresh_in = 1'b0;
    logic [7:0] boot_cfg_in = 8'h00;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, wdt_enable_out, refresh_sync_out, lock_out, busy_out;
    logic [7:0] ctrl_active_out;
    logic [13:0] timeout_cycles_out;
    logic [33:0] notes[$];
    logic [33:0] n;
    logic [7:0] cur;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 66175;
    int pulses;

    // The clock flips every half period.
    always #5 ref_clk_in = ~ref_clk_in;

    wdls_top #(.WDT_DIV(4)) u_wdls_top (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .boot_load_in(boot_load_in), .boot_cfg_in(boot_cfg_in),
        .debug_in(debug_in), .refresh_in(refresh_in), .ctrl_active_out(ctrl_active_out),
        .wdt_enable_out(wdt_enable_out), .timeout_cycles_out(timeout_cycles_out),
        .refresh_sync_out(refresh_sync_out), .lock_out(lock_out), .busy_out(busy_out)
    );

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // One APB transfer; the expectation is noted for the watcher.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        notes.push_back({~w, err, exp});
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
        end while (pready_out !== 1'b1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    // Short forms for a plain write, a read and the unlock key.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 1'b0);
    endtask
    task automatic key;
        wr(wdls_pkg::ADDR_KEY, 32'(wdls_pkg::UNLOCK_KEY));
    endtask

    // Waits, bounded, until the control crossing has finished.
    task automatic settle;
        repeat (2) @(posedge ref_clk_in);
        for (int i = 0; i < 100 && busy_out !== 1'b0; i++) @(posedge ref_clk_in);
        #1;
    endtask

    // Unlocked control write, followed through the crossing.
    task automatic ctrl_set(input logic [7:0] val);
        logic [13:0] t;
        case (val[3:0])
            4'h6: t = 14'h0100;
            4'h7: t = 14'h0200;
            4'h8: t = 14'h0400;
            4'h9: t = 14'h0800;
            4'ha: t = 14'h1000;
            4'hb: t = 14'h2000;
            default: t = wdls_pkg::TO_NONE;
        endcase
        key();
        wr(wdls_pkg::ADDR_CTRL, 32'(val));
        repeat (2) @(posedge ref_clk_in);
        #1;
        check(32'(busy_out), 32'h1);
        check(32'(ctrl_active_out), 32'(cur));
        settle();
        check(32'(busy_out), 32'h0);
        check(32'(ctrl_active_out), 32'(val));
        check(32'(wdt_enable_out), 32'(val[3:0] != 4'h0));
        check(32'(timeout_cycles_out), 32'(t));
        rd(wdls_pkg::ADDR_CTRL, 32'(val));
        cur = val;
    endtask

    // Loads a boot value and checks the automatic lock.
    task automatic boot(input logic [7:0] cfg);
        @(posedge ref_clk_in);
        boot_load_in <= 1'b1;
        boot_cfg_in <= cfg;
        @(posedge ref_clk_in);
        boot_load_in <= 1'b0;
        settle();
        check(32'(ctrl_active_out), 32'(cfg));
        check(32'(lock_out), 32'(cfg[3:0] != 4'h0));
    endtask

    // Each completed transfer is matched against the oldest noted expectation.
    always @(posedge ref_clk_in) begin
        if (pready_out === 1'b1) begin
            if (notes.size() == 0) begin
                n_errors++;
                $display("BAD t=%0t unexpected ready", $time);
            end else begin
                n = notes.pop_front();
                check(32'(pslverr_out), 32'(n[32]));
                if (n[33]) check(prdata_out, n[31:0]);
            end
        end
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        cur = 8'h00;
        rd(wdls_pkg::ADDR_STAT, 32'h0);
        rd(wdls_pkg::ADDR_CTRL, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h010, $random(seed), 32'h0, 1'b1);
        wr(wdls_pkg::ADDR_CTRL, 32'h03);
        rd(wdls_pkg::ADDR_CTRL, 32'h0);
        for (int c = 6; c <= 11; c++) ctrl_set({4'($random(seed)), 4'(c)});
        ctrl_set(8'h00);
        for (int k = 4; k >= 3; k--) begin
            key();
            repeat (k) rd(wdls_pkg::ADDR_STAT, 32'h0);
            wr(wdls_pkg::ADDR_CTRL, 32'h09);
            settle();
            if (k == 3) cur = 8'h09;
            check(32'(ctrl_active_out), 32'(cur));
        end
        wr(wdls_pkg::ADDR_STAT, 32'h80);
        rd(wdls_pkg::ADDR_STAT, 32'h00);
        key();
        wr(wdls_pkg::ADDR_STAT, 32'h81);
        rd(wdls_pkg::ADDR_STAT, 32'h80);
        check(32'(lock_out), 32'h1);
        key();
        wr(wdls_pkg::ADDR_CTRL, 32'h01);
        settle();
        rd(wdls_pkg::ADDR_CTRL, 32'(cur));
        key();
        wr(wdls_pkg::ADDR_STAT, 32'h00);
        rd(wdls_pkg::ADDR_STAT, 32'h80);
        debug_in <= 1'b1;
        key();
        wr(wdls_pkg::ADDR_STAT, 32'h00);
        rd(wdls_pkg::ADDR_STAT, 32'h00);
        debug_in <= 1'b0;
        boot(8'h30);
        boot(8'h07);
        pulses = 0;
        fork
            for (int k = 0; k < 2; k++) begin
                @(posedge ref_clk_in);
                refresh_in <= 1'b1;
                @(posedge ref_clk_in);
                refresh_in <= 1'b0;
            end
            repeat (40) begin
                @(posedge ref_clk_in);
                if (refresh_sync_out === 1'b1) pulses++;
            end
        join
        check(pulses, 32'h1);
        complete_run();
    end

    // A hang is cut short after a generous span.
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
